/* File: design/pcawd_top.sv */
// Purpose: Counter array frequency output on one module plus watchdog on module 2
// Assumes: Idle and external tick inputs synchronous to aclk
// Notes: Watchdog expiry pulses wd_reset_req; system is expected to reset the block
`timescale 1ns/100ps
module pcawd_top
    import pcawd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cpu_idle,
    input wire logic ext_clk_tick,
    output logic module_output_pin,
    output logic wd_reset_req,
    output logic irq
);
    // ============================================================
    // Bus front end
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_hit;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_hit;

    pcawd_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_hit(wr_hit),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_hit(rd_hit)
    );

    // ============================================================
    // Registers
    logic [7:0] counter_array_mode_reg;
    logic [7:0] compare_module_mode_reg;
    logic [7:0] compare_low_byte_reg;
    logic [7:0] compare_high_byte_reg;
    logic [7:0] watchdog_offset_byte_reg;
    logic [7:0] wd_high_reg;
    logic [7:0] counter_low_byte_reg;
    logic [7:0] counter_high_reg;
    logic [1:0] status_reg;
    logic [1:0] mask_reg;
    logic wd_enabled;
    logic cnt_tick;
    logic count_run;
    logic freq_mode;
    logic low_match;
    logic wd_match;
    logic wd_refresh;
    logic [1:0] events;

    assign wd_enabled = counter_array_mode_reg[PCAWD_WDE_BIT] | counter_array_mode_reg[PCAWD_LCK_BIT];
    assign count_run = cnt_tick && !(counter_array_mode_reg[PCAWD_IDLE_BIT] && cpu_idle);

    always_comb begin
        unique case (wr_addr)
            PCAWD_MODE_OFF, PCAWD_CNT_OFF, PCAWD_CMODE_OFF, PCAWD_CLOW_OFF, PCAWD_CHIGH_OFF,
            PCAWD_WDOFF_OFF, PCAWD_WDHIGH_OFF, PCAWD_STAT_OFF, PCAWD_MASK_OFF: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_data = 32'h00000000;
        unique case (rd_addr)
            PCAWD_MODE_OFF: rd_data[7:0] = counter_array_mode_reg;
            PCAWD_CNT_OFF: rd_data[15:0] = {counter_high_reg, counter_low_byte_reg};
            PCAWD_CMODE_OFF: rd_data[7:0] = compare_module_mode_reg;
            PCAWD_CLOW_OFF: rd_data[7:0] = compare_low_byte_reg;
            PCAWD_CHIGH_OFF: rd_data[7:0] = compare_high_byte_reg;
            PCAWD_WDOFF_OFF: rd_data[7:0] = watchdog_offset_byte_reg;
            PCAWD_WDHIGH_OFF: rd_data[7:0] = wd_high_reg;
            PCAWD_STAT_OFF: rd_data[1:0] = status_reg;
            PCAWD_MASK_OFF: rd_data[1:0] = mask_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    // ============================================================
    // Counter array mode register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter_array_mode_reg <= PCAWD_MODE_RST;
        end else if (wr_en && wr_addr == PCAWD_MODE_OFF) begin
            if (counter_array_mode_reg[PCAWD_LCK_BIT]) begin
                counter_array_mode_reg <= counter_array_mode_reg;
            end else if (wd_enabled) begin
                // Clock select and idle choice frozen while enabled
                counter_array_mode_reg[PCAWD_WDE_BIT] <= wr_data[PCAWD_WDE_BIT];
                counter_array_mode_reg[PCAWD_LCK_BIT] <= wr_data[PCAWD_LCK_BIT];
            end else begin
                counter_array_mode_reg <= wr_data & 8'hee;
            end
        end
    end

    // ============================================================
    // Compare module registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_module_mode_reg <= 8'h00;
            compare_high_byte_reg <= 8'h00;
            watchdog_offset_byte_reg <= 8'h00;
        end else if (wr_en) begin
            if (wr_addr == PCAWD_CMODE_OFF) begin
                compare_module_mode_reg <= wr_data;
            end
            if (wr_addr == PCAWD_CHIGH_OFF) begin
                compare_high_byte_reg <= wr_data;
            end
            if (wr_addr == PCAWD_WDOFF_OFF) begin
                watchdog_offset_byte_reg <= wr_data;
            end
        end
    end

    assign freq_mode = compare_module_mode_reg[PCAWD_ECOM_BIT] && compare_module_mode_reg[PCAWD_TOG_BIT]
        && compare_module_mode_reg[PCAWD_PWM_BIT];
    assign low_match = count_run && freq_mode && (counter_low_byte_reg == compare_low_byte_reg);

    // Adding zero wraps the low byte by 256 counter ticks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_low_byte_reg <= 8'h00;
        end else if (low_match) begin
            compare_low_byte_reg <= compare_low_byte_reg + compare_high_byte_reg;
        end else if (wr_en && wr_addr == PCAWD_CLOW_OFF) begin
            compare_low_byte_reg <= wr_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            module_output_pin <= 1'b0;
        end else if (low_match) begin
            module_output_pin <= !module_output_pin;
        end
    end

    // ============================================================
    // Free-running counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter_low_byte_reg <= 8'h00;
            counter_high_reg <= 8'h00;
        end else if (wr_en && wr_addr == PCAWD_CNT_OFF && !wd_enabled) begin
            counter_low_byte_reg <= wr_data;
        end else if (count_run) begin
            {counter_high_reg, counter_low_byte_reg} <= {counter_high_reg, counter_low_byte_reg} + 16'h0001;
        end
    end

    pcawd_prescale u_pre (
        .aclk(aclk),
        .aresetn(aresetn),
        .sel(counter_array_mode_reg[PCAWD_CPS_LSB +: 3]),
        .ext_tick(ext_clk_tick),
        .tick(cnt_tick)
    );

    // ============================================================
    // Watchdog on module 2
    assign wd_refresh = wr_en && wr_addr == PCAWD_WDHIGH_OFF;
    assign wd_match = count_run && wd_enabled && (counter_high_reg == wd_high_reg)
        && (counter_low_byte_reg == 8'hff);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_high_reg <= 8'h00;
        end else if (wd_refresh) begin
            wd_high_reg <= counter_high_reg + watchdog_offset_byte_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_reset_req <= 1'b0;
        end else begin
            wd_reset_req <= wd_match && !wd_refresh;
        end
    end

    // ============================================================
    // Interrupts
    assign events = {wd_match && !wd_refresh, low_match};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= 2'h0;
        end else begin
            if (wr_en && wr_addr == PCAWD_STAT_OFF) begin
                status_reg <= (status_reg & ~wr_data[1:0]) | events;
            end else begin
                status_reg <= status_reg | events;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_reg <= 2'h0;
        end else if (wr_en && wr_addr == PCAWD_MASK_OFF) begin
            mask_reg <= wr_data[1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_reg & mask_reg);
        end
    end
endmodule : pcawd_top

/* File: design/pcawd_pkg.sv */
// Purpose: Constants for the counter array frequency output and watchdog block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: Register offsets are byte addresses
package pcawd_pkg;
    // ============================================================
    // Register map
    localparam logic [7:0] PCAWD_MODE_OFF = 8'h00;
    localparam logic [7:0] PCAWD_CNT_OFF = 8'h04;
    localparam logic [7:0] PCAWD_CMODE_OFF = 8'h08;
    localparam logic [7:0] PCAWD_CLOW_OFF = 8'h0c;
    localparam logic [7:0] PCAWD_CHIGH_OFF = 8'h10;
    localparam logic [7:0] PCAWD_WDOFF_OFF = 8'h14;
    localparam logic [7:0] PCAWD_WDHIGH_OFF = 8'h18;
    localparam logic [7:0] PCAWD_STAT_OFF = 8'h1c;
    localparam logic [7:0] PCAWD_MASK_OFF = 8'h20;
    // ============================================================
    // Mode register fields
    localparam int PCAWD_IDLE_BIT = 7;
    localparam int PCAWD_WDE_BIT = 6;
    localparam int PCAWD_LCK_BIT = 5;
    localparam int PCAWD_CPS_LSB = 1;
    localparam logic [7:0] PCAWD_MODE_RST = 8'h40;
    // Compare module mode fields
    localparam int PCAWD_ECOM_BIT = 6;
    localparam int PCAWD_PWM_BIT = 1;
    localparam int PCAWD_TOG_BIT = 2;
    // Status bits
    localparam int PCAWD_ST_TOG = 0;
    localparam int PCAWD_ST_WD = 1;
    // ============================================================
    // Clock sources, divider limits and bus responses
    localparam logic [2:0] PCAWD_CPS_DIV12 = 3'h0;
    localparam logic [2:0] PCAWD_CPS_DIV4 = 3'h1;
    localparam logic [2:0] PCAWD_CPS_EXT = 3'h2;
    localparam logic [2:0] PCAWD_CPS_SYS = 3'h4;
    localparam logic [3:0] PCAWD_DIV12_LAST = 4'hb;
    localparam logic [3:0] PCAWD_DIV4_LAST = 4'h3;
    localparam logic [3:0] PCAWD_DIV_ZERO = 4'h0;
    localparam logic [1:0] PCAWD_RESP_OKAY = 2'h0;
    localparam logic [1:0] PCAWD_RESP_SLVERR = 2'h2;
endpackage : pcawd_pkg

/* File: design/pcawd_prescale.sv */
// Purpose: Counter array clock enable generator
// Assumes: Ext tick synchronous to aclk
// Notes: One-cycle tick per counter array clock
`timescale 1ns/100ps
module pcawd_prescale
    import pcawd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] sel,
    input wire logic ext_tick,
    output logic tick
);
    logic [3:0] div_reg;
    logic [3:0] last;

    always_comb begin
        last = (sel == PCAWD_CPS_DIV4) ? PCAWD_DIV4_LAST : PCAWD_DIV12_LAST;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_reg <= PCAWD_DIV_ZERO;
        end else if (div_reg >= last) begin
            div_reg <= PCAWD_DIV_ZERO;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick <= 1'b0;
        end else begin
            unique case (sel)
                PCAWD_CPS_DIV12, PCAWD_CPS_DIV4: tick <= (div_reg >= last);
                PCAWD_CPS_EXT: tick <= ext_tick;
                PCAWD_CPS_SYS: tick <= 1'b1;
                default: tick <= 1'b0;
            endcase
        end
    end
endmodule : pcawd_prescale

/* File: design/pcawd_axil.sv */
// Purpose: AXI4-Lite slave front end
// Assumes: One write and one read at a time
// Notes: Produces a one-cycle write strobe; reads use a registered read address, no strobe
`timescale 1ns/100ps
module pcawd_axil
    import pcawd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    input wire logic wr_hit,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_hit
);
    logic aw_got;
    logic w_got;
    logic ar_got;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PCAWD_RESP_OKAY;
            wr_en <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            wr_en <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                s_axi_awready <= 1'b0;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                s_axi_wready <= 1'b0;
                wr_data <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
            end
            if (aw_got && w_got && !s_axi_bvalid) begin
                wr_en <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? PCAWD_RESP_OKAY : PCAWD_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_got <= 1'b0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= PCAWD_RESP_OKAY;
            rd_addr <= 8'h00;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                ar_got <= 1'b1;
                s_axi_arready <= 1'b0;
                rd_addr <= s_axi_araddr;
            end
            if (ar_got && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_hit ? rd_data : 32'h00000000;
                s_axi_rresp <= rd_hit ? PCAWD_RESP_OKAY : PCAWD_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                ar_got <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule : pcawd_axil

/* File: test/pcawd_checker.sv */
// Purpose: Port-level assertions for the counter array watchdog block
// Assumes: Single aclk domain, synchronous active-low reset
// Notes: Watchdog window figures assume reset defaults and no writes
`timescale 1ns/100ps
module pcawd_checker
    import pcawd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wd_reset_req
);
    // ============================================================
    // Helpers: cycles since reset, write seen, expiry seen
    logic [12:0] age_reg;
    logic wrote_reg;
    logic fired_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            age_reg <= 13'h0;
            wrote_reg <= 1'b0;
            fired_reg <= 1'b0;
        end else begin
            if (age_reg != 13'h1fff) age_reg <= age_reg + 13'h1;
            if (s_axi_awvalid) wrote_reg <= 1'b1;
            if (wd_reset_req) fired_reg <= 1'b1;
        end
    end
    // ============================================================
    // Properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_wr_answer;
        s_wr_taken |-> ##[1:2] s_axi_bvalid;
    endproperty
    property p_wr_busy;
        s_wr_taken |=> (!s_axi_awready && !s_axi_wready) until (s_axi_bvalid && s_axi_bready);
    endproperty
    property p_rd_busy;
        s_rd_taken |=> !s_axi_arready until (s_axi_rvalid && s_axi_rready);
    endproperty
    property p_rd_unmapped;
        s_rd_taken and (s_axi_araddr > 8'h20) |->
            ##[1:2] (s_axi_rvalid && s_axi_rresp == PCAWD_RESP_SLVERR && s_axi_rdata == 32'h0);
    endproperty
    property p_rd_mode;
        s_rd_taken and (s_axi_araddr == PCAWD_MODE_OFF) |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == PCAWD_RESP_OKAY);
    endproperty
    property p_wd_pulse;
        $rose(wd_reset_req) |=> !wd_reset_req;
    endproperty
    property p_wd_not_early;
        !wrote_reg && age_reg < 13'd3055 |-> !wd_reset_req;
    endproperty
    property p_wd_deadline;
        !wrote_reg && age_reg == 13'd3110 |-> fired_reg;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write response late");
    a_wr_busy: assert property (p_wr_busy) else $error("write ready during transfer");
    a_rd_busy: assert property (p_rd_busy) else $error("read ready during transfer");
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");
    a_rd_mode: assert property (p_rd_mode) else $error("mode read not answered");
    a_wd_pulse: assert property (p_wd_pulse) else $error("expiry pulse too long");
    a_wd_not_early: assert property (p_wd_not_early) else $error("watchdog expired early");
    a_wd_deadline: assert property (p_wd_deadline) else $error("watchdog expired late");
endmodule : pcawd_checker

bind pcawd_top pcawd_checker chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .wd_reset_req(wd_reset_req));

/* File: test/pcawd_top_test.sv */
// Purpose: Self-checking bench for frequency output and watchdog
// Assumes: AXI4-Lite master driven on rising edges
// Notes: Timing windows allow for prescaler phase
`timescale 1ns/100ps
module pcawd_top_test
    import pcawd_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic cpu_idle = 1'b0;
    logic ext_clk_tick = 1'b0;
    logic module_output_pin;
    logic wd_reset_req;
    logic irq;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int rel_cyc = 0;
    int last_tog = 0;
    int tog_gap = 0;
    int tog_cnt = 0;
    int wd_cnt = 0;
    logic pin_q = 1'b0;

    always #12.5 aclk = ~aclk;

    pcawd_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .cpu_idle, .ext_clk_tick, .module_output_pin, .wd_reset_req, .irq);

    // ============================================================
    // Monitors and external tick source
    always @(posedge aclk) begin
        cyc++;
        if (module_output_pin !== pin_q) begin
            tog_gap = cyc - last_tog;
            last_tog = cyc;
            tog_cnt++;
        end
        pin_q = module_output_pin;
        if (wd_reset_req === 1'b1) wd_cnt++;
        ext_clk_tick <= ~ext_clk_tick;
    end

    // ============================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic do_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        rel_cyc = cyc;
    endtask : do_reset

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        r = 2'h3;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r = 2'h3;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask : axi_read

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        check(r, PCAWD_RESP_OKAY);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check(r, PCAWD_RESP_OKAY);
        check(d & m, e);
    endtask : rd_chk

    task automatic wait_wd(input int lim, output int n);
        for (n = 0; n < lim; n++) begin
            @(posedge aclk);
            if (wd_reset_req === 1'b1) break;
        end
        @(negedge aclk);
    endtask : wait_wd

    // ============================================================
    // Scenarios
    task automatic test_default_expiry;
        int n;
        do_reset();
        rd_chk(PCAWD_MODE_OFF, 32'hee, 32'h40);
        rd_chk(PCAWD_WDOFF_OFF, 32'hff, 32'h0);
        wait_wd(3300, n);
        check((cyc - rel_cyc) >= 3055 && (cyc - rel_cyc) <= 3110, 1'b1);
        rd_chk(PCAWD_STAT_OFF, 32'h2, 32'h2);
        check(irq, 1'b0);
        wr(PCAWD_MASK_OFF, 32'h2);
        repeat (2) @(posedge aclk);
        check(irq, 1'b1);
        wr(PCAWD_STAT_OFF, 32'h2);
        repeat (2) @(posedge aclk);
        check(irq, 1'b0);
        $display("test_default_expiry done");
    endtask : test_default_expiry

    task automatic test_lock;
        int n;
        do_reset();
        wr(PCAWD_MODE_OFF, 32'h20);
        rd_chk(PCAWD_MODE_OFF, 32'hee, 32'h20);
        wr(PCAWD_MODE_OFF, 32'h00);
        wr(PCAWD_MODE_OFF, 32'h88);
        rd_chk(PCAWD_MODE_OFF, 32'hee, 32'h20);
        wait_wd(3300, n);
        check(n < 3300, 1'b1);
        do_reset();
        rd_chk(PCAWD_MODE_OFF, 32'hee, 32'h40);
        $display("test_lock done");
    endtask : test_lock

    task automatic test_idle_refresh;
        int n;
        int c;
        do_reset();
        wr(PCAWD_MODE_OFF, 32'h00);
        rd_chk(PCAWD_MODE_OFF, 32'hee, 32'h00);
        wr(PCAWD_MODE_OFF, 32'h88);
        wr(PCAWD_WDOFF_OFF, 32'h01);
        rd_chk(PCAWD_WDOFF_OFF, 32'hff, 32'h01);
        wr(PCAWD_MODE_OFF, 32'hc8);
        wr(PCAWD_MODE_OFF, 32'h40);
        rd_chk(PCAWD_MODE_OFF, 32'hee, 32'hc8);
        cpu_idle <= 1'b1;
        wr(PCAWD_WDHIGH_OFF, 32'h0);
        c = wd_cnt;
        repeat (1000) @(posedge aclk);
        check(wd_cnt, c);
        cpu_idle <= 1'b0;
        wr(PCAWD_WDHIGH_OFF, 32'h0);
        wait_wd(600, n);
        check(n >= 250 && n <= 515, 1'b1);
        $display("test_idle_refresh done");
    endtask : test_idle_refresh

    task automatic test_freq;
        logic [7:0] sel [4] = '{8'h08, 8'h02, 8'h00, 8'h04};
        int div [4] = '{1, 4, 12, 2};
        int c;
        do_reset();
        wr(PCAWD_MODE_OFF, 32'h00);
        wr(PCAWD_CHIGH_OFF, 32'h04);
        wr(PCAWD_CLOW_OFF, 32'h00);
        wr(PCAWD_CMODE_OFF, 32'h46);
        // Align counter with the compare value so toggling starts at once
        wr(PCAWD_CNT_OFF, 32'h00);
        for (int i = 0; i < 4; i++) begin
            wr(PCAWD_MODE_OFF, sel[i]);
            repeat (16 * div[i] + 8) @(posedge aclk);
            @(negedge aclk);
            check(tog_gap, 4 * div[i]);
        end
        wr(PCAWD_MODE_OFF, 32'h08);
        wr(PCAWD_CHIGH_OFF, 32'h00);
        repeat (600) @(posedge aclk);
        @(negedge aclk);
        check(tog_gap, 256);
        check(irq, 1'b0);
        wr(PCAWD_MASK_OFF, 32'h1);
        repeat (2) @(posedge aclk);
        check(irq, 1'b1);
        wr(PCAWD_CMODE_OFF, 32'h06);
        wr(PCAWD_STAT_OFF, 32'h1);
        rd_chk(PCAWD_STAT_OFF, 32'h1, 32'h0);
        check(irq, 1'b0);
        c = tog_cnt;
        repeat (600) @(posedge aclk);
        check(tog_cnt, c);
        $display("test_freq done");
    endtask : test_freq

    task automatic test_unmapped;
        logic [31:0] d;
        logic [1:0] r;
        axi_read(8'h40, d, r);
        check(r, PCAWD_RESP_SLVERR);
        check(d, 32'h0);
        axi_write(8'h40, 32'h5a, r);
        check(r, PCAWD_RESP_SLVERR);
        $display("test_unmapped done");
    endtask : test_unmapped

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    initial begin
        test_default_expiry();
        test_lock();
        test_idle_refresh();
        test_freq();
        test_unmapped();
        stop_test();
    end

    initial begin
        #(40000 * 25);
        bad_count++;
        $display("Run cut short by watchdog");
        stop_test();
    end
endmodule : pcawd_top_test
